//--- rvss_pkg.sv
// constants, types and register map of the regulator sequencer
package rvss_pkg;
  // clock and internal timebases
  localparam int unsigned PCLK_PS        = 25000;
  localparam logic [9:0]  CLK16_INC      = 10'h002;  // 16 MHz = 40 MHz * 2 / 5
  localparam logic [9:0]  CLK16_MOD      = 10'h005;
  localparam int unsigned HALF_WAIT_PS   = 31250;    // half of a 16 MHz period
  localparam logic [1:0]  HALF_WAIT_CYC  = 2'((HALF_WAIT_PS + PCLK_PS - 1) / PCLK_PS);
  localparam int unsigned TRACK_STEP_NS  = 4000;
  localparam logic [10:0] TRACK_STEP_CYC = 11'(TRACK_STEP_NS * 1000 / PCLK_PS);
  localparam int unsigned RAMP_STEP_NS   = 32000;
  localparam logic [10:0] RAMP_STEP_CYC  = 11'(RAMP_STEP_NS * 1000 / PCLK_PS);
  // counts in switching cycles
  localparam logic [6:0]  SS_DELAY_SW    = 7'h40;    // 64
  localparam logic [9:0]  OFS_DECAY_SW   = 10'h280;  // 640, stands for 100 mV
  localparam logic [6:0]  NOLOAD_WAIT_SW = 7'h02;
  // codes and levels, levels in 12.5 mV units from 0 V
  localparam logic [5:0]  NOLOAD_CODE    = 6'h3f;
  localparam logic [6:0]  DAC_BASE_LSB   = 7'h2a;    // 0.525 V
  // register map and fields
  localparam logic [11:0] CTRL_OFS       = 12'h000;
  localparam logic [11:0] STAT_OFS       = 12'h004;
  localparam logic [9:0]  CTRL_PERIOD_RST = 10'h050; // 80 clocks = 500 kHz
  localparam int unsigned STAT_DAC_POS   = 0;
  localparam int unsigned STAT_CODE_POS  = 7;
  localparam int unsigned STAT_ST_POS    = 13;
  localparam int unsigned STAT_PG_POS    = 18;
  localparam int unsigned STAT_OVL_POS   = 19;
  localparam int unsigned STAT_PWM_POS   = 20;
  localparam int unsigned STAT_OFS_POS   = 21;
  // sequencer states
  typedef enum logic [4:0] {
    ST_OFF   = 5'h01,
    ST_DELAY = 5'h02,
    ST_RAMP  = 5'h04,
    ST_RUN   = 5'h08,
    ST_NLW   = 5'h10
  } rvss_state_t;
  // overvoltage trip level selection
  typedef enum logic [1:0] {
    TRIP_PRE  = 2'h0,
    TRIP_SOFT = 2'h1,
    TRIP_RUN  = 2'h2,
    TRIP_SHUT = 2'h3
  } rvss_trip_t;
endpackage

//--- rvss_strobe_gen.sv
// fractional divider giving one-clock strobes at inc/modulus of pclk
`timescale 1ns/100ps
module rvss_strobe_gen (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [9:0] inc,
  input  wire logic [9:0] modulus,
  output logic            strobe
);
  import rvss_pkg::*;

  typedef struct packed {
    logic [10:0] acc;
    logic        stb;
  } rvss_div_t;

  rvss_div_t q;
  rvss_div_t d;
  logic [10:0] sum;

  // accumulate and wrap, strobe on wrap
  always_comb begin
    d   = q;
    sum = q.acc + {1'b0, inc};
    if (sum >= {1'b0, modulus}) begin
      d.acc = sum - {1'b0, modulus};
      d.stb = 1'b1;
    end else begin
      d.acc = sum;
      d.stb = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign strobe = q.stb;
endmodule

//--- rvss_sequencer.sv
// voltage code tracking, enable gating, soft-start and power-good core
//
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/100ps
module rvss_sequencer (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       psel,
  input  wire logic       penable,
  input  wire logic       pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]     prdata,
  output logic            pready,
  output logic            pslverr,
  input  wire logic [5:0] voltage_ident_code,
  input  wire logic       bias_por_ok,
  input  wire logic       en_above_thr,
  input  wire logic       logic_level_enable_in,
  input  wire logic       ov_detect,
  input  wire logic [7:0] remote_sense_voltage,
  output logic            pwm_oe,
  output logic [6:0]      dac_level,
  output logic [9:0]      sense_offset,
  output rvss_pkg::rvss_trip_t ov_trip_sel,
  output logic            power_ok_out_oe
);
  import rvss_pkg::*;

  typedef struct packed {
    rvss_state_t st;
    logic [5:0]  smp0;
    logic [5:0]  smp1;
    logic [5:0]  smp2;
    logic [5:0]  target;
    logic [6:0]  dac;
    logic [1:0]  pend;
    logic        pend_up;
    logic [10:0] tmr;
    logic [6:0]  swc;
    logic [9:0]  ofs;
    logic        pwm_oe;
    logic        pg_oe;
    logic        ovl;
    rvss_trip_t  trip;
    logic [9:0]  period;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } rvss_regs_t;

  localparam rvss_regs_t RST = '{st: ST_OFF, smp0: NOLOAD_CODE, smp1: NOLOAD_CODE,
    smp2: NOLOAD_CODE, target: NOLOAD_CODE, dac: '0, pend: '0, pend_up: 1'b0,
    tmr: '0, swc: '0, ofs: '0, pwm_oe: 1'b0, pg_oe: 1'b1, ovl: 1'b0,
    trip: TRIP_PRE, period: CTRL_PERIOD_RST, prdata: '0, pready: 1'b0,
    pslverr: 1'b0};

  rvss_regs_t q;
  rvss_regs_t d;
  logic       s16;
  logic       sw;
  logic       enabled;
  logic       uv;
  logic [6:0] tgt_lvl;

  // code to level in 12.5 mV units
  function automatic logic [6:0] lvl(input logic [5:0] code);
    lvl = DAC_BASE_LSB + {1'b0, code};
  endfunction

  // one LSB toward the goal
  function automatic logic [6:0] toward(input logic [6:0] cur, input logic [6:0] goal);
    if (goal > cur) begin
      toward = cur + 7'h01;
    end else if (goal < cur) begin
      toward = cur - 7'h01;
    end else begin
      toward = cur;
    end
  endfunction

  // 16 MHz sampling strobe
  rvss_strobe_gen u_clk16 (
    .pclk    (pclk),
    .presetn (presetn),
    .inc     (CLK16_INC),
    .modulus (CLK16_MOD),
    .strobe  (s16)
  );

  // switching-period strobe, period set by software
  rvss_strobe_gen u_swclk (
    .pclk    (pclk),
    .presetn (presetn),
    .inc     (10'h001),
    .modulus (q.period),
    .strobe  (sw)
  );

  // enable inputs and undervoltage compare at 75 percent of code level
  assign enabled = bias_por_ok && en_above_thr && logic_level_enable_in;
  assign tgt_lvl = lvl(q.target);
  assign uv      = {1'b0, remote_sense_voltage} < 9'(({2'b00, tgt_lvl} * 9'h003) >> 2);

  // next-state logic
  always_comb begin
    d = q;
    // code sampling on the 16 MHz strobe
    if (s16) begin
      d.smp0 = voltage_ident_code;
      d.smp1 = q.smp0;
      d.smp2 = q.smp1;
    end
    // three agreeing samples that differ make a new request
    if (q.smp0 == q.smp1 && q.smp1 == q.smp2 && q.smp0 != q.target) begin
      d.target = q.smp0;
      if (q.st == ST_RUN) begin
        d.pend    = HALF_WAIT_CYC;
        d.pend_up = lvl(q.smp0) > q.dac;
      end
    end
    // sense offset decays once the start delay is over
    if (sw && q.ofs != '0 && (q.st == ST_RAMP || q.st == ST_RUN || q.st == ST_NLW)) begin
      d.ofs = q.ofs - 10'h001;
    end
    if (!enabled) begin
      // disable from bias, enable or logic enable forces shutdown, clears the overvoltage latch and trip level; dac and offset are kept
      d.st     = ST_OFF;
      d.pwm_oe = 1'b0;
      d.pg_oe  = 1'b1;
      d.ovl    = 1'b0;
      d.trip   = TRIP_PRE;
      d.pend   = '0;
    end else if (q.ovl || ov_detect) begin
      // latched overvoltage holds shutdown, power good untouched
      d.ovl    = 1'b1;
      d.st     = ST_OFF;
      d.pwm_oe = 1'b0;
      d.trip   = TRIP_SHUT;
      d.pg_oe  = q.pg_oe;
      d.pend   = '0;
    end else begin
      case (q.st)
        ST_OFF: begin
          d.pwm_oe = 1'b0;
          d.pg_oe  = 1'b1;
          if (q.target != NOLOAD_CODE) begin
            d.st   = ST_DELAY;
            d.swc  = '0;
            d.dac  = '0;
            d.ofs  = OFS_DECAY_SW;
            d.trip = TRIP_SOFT;
          end
        end
        ST_DELAY: begin
          if (q.target == NOLOAD_CODE) begin
            d.st  = ST_NLW;
            d.swc = '0;
          end else if (sw) begin
            d.swc = q.swc + 7'h01;
            if (q.swc == SS_DELAY_SW - 7'h01) begin
              d.st  = ST_RAMP;
              d.tmr = RAMP_STEP_CYC;
            end
          end
        end
        ST_RAMP: begin
          if (q.target == NOLOAD_CODE) begin
            d.st  = ST_NLW;
            d.swc = '0;
          end else if (q.dac == tgt_lvl) begin
            d.st     = ST_RUN;
            d.trip   = TRIP_RUN;
            d.pwm_oe = 1'b1;
            d.pg_oe  = uv;
            d.tmr    = '0;
          end else begin
            if ({1'b0, q.dac} >= remote_sense_voltage) begin
              d.pwm_oe = 1'b1;
            end
            if (q.tmr <= 11'h001) begin
              d.dac = toward(q.dac, tgt_lvl);
              d.tmr = RAMP_STEP_CYC;
            end else begin
              d.tmr = q.tmr - 11'h001;
            end
          end
        end
        ST_RUN: begin
          d.pg_oe = uv;
          if (q.target == NOLOAD_CODE) begin
            d.st   = ST_NLW;
            d.swc  = '0;
            d.pend = '0;
          end else if (q.pend != '0) begin
            d.pend = q.pend - 2'h1;
            if (q.pend == 2'h1) begin
              d.tmr = TRACK_STEP_CYC;
              if (q.dac != tgt_lvl && (tgt_lvl > q.dac) == q.pend_up) begin
                d.dac = toward(q.dac, tgt_lvl);
              end
            end
          end else if (q.tmr != '0) begin
            d.tmr = q.tmr - 11'h001;
            if (q.tmr == 11'h001 && q.dac != tgt_lvl) begin
              d.dac = toward(q.dac, tgt_lvl);
              d.tmr = TRACK_STEP_CYC;
            end
          end
        end
        ST_NLW: begin
          if (q.target != NOLOAD_CODE) begin
            d.st  = ST_DELAY;
            d.swc = '0;
            d.dac = '0;
            d.ofs = OFS_DECAY_SW;
            d.trip = TRIP_SOFT;
            d.pwm_oe = 1'b0;
            d.pg_oe = 1'b1;
          end else if (sw) begin
            d.swc = q.swc + 7'h01;
            if (q.swc == NOLOAD_WAIT_SW - 7'h01) begin
              d.st     = ST_OFF;
              d.trip   = TRIP_SHUT;
              d.pwm_oe = 1'b0;
              d.pg_oe  = 1'b1;
            end
          end
        end
        default: begin
          d.st = ST_OFF;
        end
      endcase
    end
    // apb slave, no wait states: decode in setup, complete in access
    d.pready  = 1'b0;
    d.pslverr = 1'b0;
    if (psel && !penable) begin
      d.pready = 1'b1;
      d.prdata = '0;
      if (paddr == CTRL_OFS) begin
        d.prdata[9:0] = q.period;
      end else if (paddr == STAT_OFS) begin
        d.prdata[STAT_DAC_POS +: 7]  = q.dac;
        d.prdata[STAT_CODE_POS +: 6] = q.target;
        d.prdata[STAT_ST_POS +: 5]   = q.st;
        d.prdata[STAT_PG_POS]        = !q.pg_oe;
        d.prdata[STAT_OVL_POS]       = q.ovl;
        d.prdata[STAT_PWM_POS]       = q.pwm_oe;
        d.prdata[STAT_OFS_POS +: 10] = q.ofs;
      end else begin
        d.pslverr = 1'b1;
      end
    end else if (psel && penable && q.pready && pwrite && paddr == CTRL_OFS) begin
      d.period = pwdata[9:0];
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= RST;
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state register
  assign prdata          = q.prdata;
  assign pready          = q.pready;
  assign pslverr         = q.pslverr;
  assign pwm_oe          = q.pwm_oe;
  assign dac_level       = q.dac;
  assign sense_offset    = q.ofs;
  assign ov_trip_sel     = q.trip;
  assign power_ok_out_oe = q.pg_oe;

  // checks
  a_off_no_pwm: assert property (@(posedge pclk) disable iff (!presetn)
    q.st == ST_OFF |-> !q.pwm_oe) else $error("phase outputs active in shutdown");
  a_start_at_once: assert property (@(posedge pclk) disable iff (!presetn)
    q.st == ST_OFF && enabled && !q.ovl && !ov_detect && q.target != NOLOAD_CODE
    |=> q.st == ST_DELAY && q.ofs == OFS_DECAY_SW) else $error("start not taken");
  a_noload_wait: assert property (@(posedge pclk) disable iff (!presetn)
    q.st == ST_NLW && $past(q.st) != ST_NLW
    |-> $stable(q.pwm_oe) && q.trip != TRIP_SHUT)
    else $error("no-load shutdown too early");
  a_noload_end: assert property (@(posedge pclk) disable iff (!presetn)
    q.st == ST_OFF && $past(q.st) == ST_NLW && $past(enabled) && !$past(ov_detect)
    |-> q.trip == TRIP_SHUT && !q.pwm_oe && q.pg_oe)
    else $error("no-load shutdown incomplete");
  a_ovl_kept: assert property (@(posedge pclk) disable iff (!presetn)
    q.ovl && enabled |=> q.ovl && q.st == ST_OFF) else $error("overvoltage latch lost");
  a_ramp_done: assert property (@(posedge pclk) disable iff (!presetn)
    q.st == ST_RAMP && q.dac == tgt_lvl && enabled && !q.ovl && !ov_detect
    && q.target != NOLOAD_CODE |=> q.st == ST_RUN) else $error("ramp end missed");
  a_step_one: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(q.dac) && q.st == ST_RUN |-> q.dac == $past(q.dac) + 7'h01
    || q.dac == $past(q.dac) - 7'h01) else $error("dac jumped");
  a_ofs_hold: assert property (@(posedge pclk) disable iff (!presetn)
    q.st == ST_DELAY |-> q.ofs == OFS_DECAY_SW) else $error("offset decays early");
  a_pg_shut: assert property (@(posedge pclk) disable iff (!presetn)
    q.st == ST_OFF && !q.ovl |-> q.pg_oe) else $error("power good high in shutdown");
  a_pg_uv: assert property (@(posedge pclk) disable iff (!presetn)
    q.st == ST_RUN && enabled && !q.ovl && !ov_detect && q.target != NOLOAD_CODE
    |=> q.pg_oe == $past(uv)) else $error("power good not following undervoltage");
  a_ov_no_pg: assert property (@(posedge pclk) disable iff (!presetn)
    enabled && ov_detect && !q.pg_oe |=> !q.pg_oe) else $error("overvoltage pulled power good");
  // soft-start, tracking and shutdown checks
  a_ramp_up: assert property (@(posedge pclk) disable iff (!presetn)
    q.st == ST_RAMP && $changed(q.dac) |-> q.dac == $past(q.dac) + 7'h01)
    else $error("ramp step not one lsb up");
  a_pwm_prebias: assert property (@(posedge pclk) disable iff (!presetn)
    q.st == ST_RAMP && $rose(q.pwm_oe) |-> $past(q.dac) >= $past(remote_sense_voltage))
    else $error("phase outputs on below pre-bias level");
  a_ofs_decay: assert property (@(posedge pclk) disable iff (!presetn)
    sw && q.st == ST_RAMP && q.ofs != 10'h000 && enabled && !q.ovl && !ov_detect
    && q.target != NOLOAD_CODE |=> q.ofs == $past(q.ofs) - 10'h001)
    else $error("offset not decaying");
  a_half_wait: assert property (@(posedge pclk) disable iff (!presetn)
    q.st == ST_RUN && q.pend == 2'h2 |=> $stable(q.dac)) else $error("step before half wait");
  a_trip_shut: assert property (@(posedge pclk) disable iff (!presetn)
    q.trip == TRIP_SHUT |-> !q.pwm_oe) else $error("phase outputs active at shutdown trip");
endmodule

//--- rvss_cpu_model.sv
// processor-side model driving the voltage code and the logic enable
`timescale 1ns/100ps
module rvss_cpu_model (
  input  wire logic       pclk,
  output logic [5:0]      voltage_ident_code,
  output logic            logic_level_enable_in
);
  import rvss_pkg::*;
  // power-up: no-load code, controller held off
  initial begin
    voltage_ident_code    = NOLOAD_CODE;
    logic_level_enable_in = 1'b0;
  end
  // polite walk, one lsb per step, held well past a tracking step
  task automatic walk_to(input logic [5:0] c);
    while (voltage_ident_code != c) begin
      @(posedge pclk);
      voltage_ident_code <= (voltage_ident_code < c) ? voltage_ident_code + 6'h01
                                                     : voltage_ident_code - 6'h01;
      repeat (200) @(posedge pclk);
    end
  endtask
  // multi-lsb jump, tolerated but discouraged
  task automatic jump(input logic [5:0] c);
    @(posedge pclk);
    voltage_ident_code <= c;
  endtask
  // one-clock glitch, too short for three agreeing samples
  task automatic glitch(input logic [5:0] c);
    logic [5:0] keep;
    keep = voltage_ident_code;
    @(posedge pclk);
    voltage_ident_code <= c;
    @(posedge pclk);
    voltage_ident_code <= keep;
  endtask
  task automatic set_enable(input logic b);
    @(posedge pclk);
    logic_level_enable_in <= b;
  endtask
endmodule

//--- rvss_tb.sv
// self-checking bench for the regulator sequencer
`timescale 1ns/100ps
module tb;
  import rvss_pkg::*;
  localparam logic [31:0] SM  = 32'h1f << STAT_ST_POS;
  localparam logic [31:0] OVB = 32'h1 << STAT_OVL_POS;
  localparam int          UVT = 3 * (int'(DAC_BASE_LSB) + 5) / 4;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, lfsr_q;
  logic        bias_por_ok, en_above_thr, ov_detect, logic_level_enable_in;
  logic        pwm_oe, power_ok_out_oe;
  logic [5:0]  voltage_ident_code;
  logic [7:0]  remote_sense_voltage;
  logic [6:0]  dac_level;
  logic [9:0]  sense_offset;
  rvss_trip_t  ov_trip_sel;
  logic [31:0] exp_q[$], msk_q[$];
  logic        err_q[$];
  int          err_total, check_count, n;

  rvss_sequencer rvss_sequencer_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .voltage_ident_code(voltage_ident_code),
    .bias_por_ok(bias_por_ok), .en_above_thr(en_above_thr),
    .logic_level_enable_in(logic_level_enable_in), .ov_detect(ov_detect),
    .remote_sense_voltage(remote_sense_voltage), .pwm_oe(pwm_oe), .dac_level(dac_level),
    .sense_offset(sense_offset), .ov_trip_sel(ov_trip_sel),
    .power_ok_out_oe(power_ok_out_oe));
  rvss_cpu_model rvss_cpu_model_inst (.pclk(pclk), .voltage_ident_code(voltage_ident_code),
    .logic_level_enable_in(logic_level_enable_in));

  // 40 MHz clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  // bounded wait: sel 0 on dac level, sel 1 on trip selection
  task automatic wait_for(input int sel, input logic [6:0] v, input int lim, output int k);
    k = 0;
    while (k < lim && !((sel == 0 && dac_level === v) ||
                        (sel == 1 && ov_trip_sel === rvss_trip_t'(v[1:0])))) begin
      @(posedge pclk);
      k++;
    end
    if (k >= lim) begin
      err_total++;
      $display("unexpected timeout on wait %0d expected %h seen %h", sel, v, dac_level);
      finish_test();
    end
  endtask

  // apb transfer; for reads d is the expected data noted for the watcher
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                     input logic [31:0] m, input logic e);
    int k;
    @(posedge pclk);
    if (!w) begin
      exp_q.push_back(d);
      msk_q.push_back(m);
      err_q.push_back(e);
    end
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= w ? d : 32'h0;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      err_total++;
      $display("unexpected pready expected 1 seen %b", pready);
      finish_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // watcher: oldest noted read result against what the bus returns
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
      chk("prdata", exp_q[0] & msk_q[0], prdata & msk_q[0]);
      chk("pslverr", 32'(err_q[0]), 32'(pslverr));
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
      void'(err_q.pop_front());
    end
  end

  // main sequence
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0; bias_por_ok = 1'b0; en_above_thr = 1'b0; ov_detect = 1'b0;
    remote_sense_voltage = 8'h14; lfsr_q = 32'h4c267aac; err_total = 0; check_count = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    chk("reset pg", 1, power_ok_out_oe);
    chk("reset pwm", 0, pwm_oe);
    apb(CTRL_OFS, 1'b0, 32'(CTRL_PERIOD_RST), 32'h3ff, 1'b0);
    apb(12'h008, 1'b0, 32'h0, 32'hffffffff, 1'b1);
    apb(STAT_OFS, 1'b1, 32'hffffffff, 32'h0, 1'b0);
    apb(12'h00c, 1'b1, 32'h7, 32'h0, 1'b0);
    apb(CTRL_OFS, 1'b1, 32'h4, 32'h0, 1'b0);
    apb(CTRL_OFS, 1'b0, 32'h4, 32'h3ff, 1'b0);
    apb(STAT_OFS, 1'b0, 32'h1 << STAT_ST_POS, SM, 1'b0);
    // power up with a pre-biased output
    bias_por_ok <= 1'b1;
    en_above_thr <= 1'b1;
    rvss_cpu_model_inst.set_enable(1'b1);
    rvss_cpu_model_inst.jump(6'h00);
    repeat (12) @(posedge pclk);
    apb(STAT_OFS, 1'b0, 32'h2 << STAT_ST_POS, SM, 1'b0);
    chk("ofs entry", 32'(OFS_DECAY_SW), 32'(sense_offset));
    chk("pwm delay", 0, pwm_oe);
    chk("pg delay", 1, power_ok_out_oe);
    wait_for(0, 7'h01, 2000, n);
    chk("ofs mid", 1, 32'(sense_offset > 0 && sense_offset < OFS_DECAY_SW));
    wait_for(0, 7'h02, 1400, n);
    chk("ramp step", 32'(RAMP_STEP_CYC), n);
    wait_for(0, 7'h04, 4000, n);
    chk("ofs end", 0, 32'(sense_offset));
    wait_for(0, 7'h13, 20000, n);
    chk("pwm prebias", 0, pwm_oe);
    wait_for(0, 7'h14, 1400, n);
    repeat (3) @(posedge pclk);
    chk("pwm on", 1, pwm_oe);
    wait_for(0, DAC_BASE_LSB, 30000, n);
    repeat (3) @(posedge pclk);
    apb(STAT_OFS, 1'b0, 32'h8 << STAT_ST_POS, SM, 1'b0);
    chk("pg uv", 1, power_ok_out_oe);
    remote_sense_voltage <= 8'h2a;
    repeat (4) @(posedge pclk);
    chk("pg back", 0, power_ok_out_oe);
    // code tracking in run
    rvss_cpu_model_inst.jump(6'h01);
    wait_for(0, 7'h2b, 20, n);
    rvss_cpu_model_inst.walk_to(6'h02);
    chk("walk", 32'h2c, 32'(dac_level));
    rvss_cpu_model_inst.glitch(6'h05);
    repeat (200) @(posedge pclk);
    chk("glitch", 32'h2c, 32'(dac_level));
    rvss_cpu_model_inst.jump(6'h05);
    wait_for(0, 7'h2d, 20, n);
    wait_for(0, 7'h2e, 200, n);
    chk("track step", 32'(TRACK_STEP_CYC), n);
    wait_for(0, 7'h2f, 200, n);
    // random sense levels around the undervoltage threshold
    for (int i = 0; i < 8; i++) begin
      lfsr_q = lfsr(lfsr_q);
      remote_sense_voltage <= {2'b00, lfsr_q[5:0]};
      repeat (4) @(posedge pclk);
      chk("pg rand", 32'(int'(remote_sense_voltage) < UVT), power_ok_out_oe);
    end
    // overvoltage latch
    remote_sense_voltage <= 8'h3c;
    repeat (4) @(posedge pclk);
    ov_detect <= 1'b1;
    @(posedge pclk);
    ov_detect <= 1'b0;
    repeat (4) @(posedge pclk);
    chk("ov trip", 32'(TRIP_SHUT), 32'(ov_trip_sel));
    chk("ov pwm", 0, pwm_oe);
    chk("ov pg", 0, power_ok_out_oe);
    rvss_cpu_model_inst.jump(NOLOAD_CODE);
    repeat (100) @(posedge pclk);
    rvss_cpu_model_inst.jump(6'h05);
    repeat (100) @(posedge pclk);
    apb(STAT_OFS, 1'b0, OVB, OVB, 1'b0);
    rvss_cpu_model_inst.set_enable(1'b0);
    repeat (3) @(posedge pclk);
    chk("pg disable", 1, power_ok_out_oe);
    rvss_cpu_model_inst.set_enable(1'b1);
    repeat (12) @(posedge pclk);
    apb(STAT_OFS, 1'b0, 32'h2 << STAT_ST_POS, SM | OVB, 1'b0);
    chk("ofs again", 32'(OFS_DECAY_SW), 32'(sense_offset));
    // unbiased output: phase outputs switch from the first ramp cycle
    remote_sense_voltage <= 8'h00;
    repeat (300) @(posedge pclk);
    chk("pwm ramp", 1, pwm_oe);
    // no-load code shuts down, any other code restarts
    rvss_cpu_model_inst.jump(NOLOAD_CODE);
    wait_for(1, 7'h03, 200, n);
    chk("noload wait", 1, 32'(n >= 6 && n <= 24));
    repeat (2) @(posedge pclk);
    chk("noload pwm", 0, pwm_oe);
    chk("noload pg", 1, power_ok_out_oe);
    apb(STAT_OFS, 1'b0, 32'h1 << STAT_ST_POS, SM, 1'b0);
    rvss_cpu_model_inst.jump(6'h06);
    repeat (12) @(posedge pclk);
    apb(STAT_OFS, 1'b0, 32'h2 << STAT_ST_POS, SM, 1'b0);
    // bias reset and enable comparator each gate the start
    bias_por_ok <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("off trip", 32'(TRIP_PRE), 32'(ov_trip_sel));
    apb(STAT_OFS, 1'b0, 32'h1 << STAT_ST_POS, SM, 1'b0);
    bias_por_ok <= 1'b1;
    en_above_thr <= 1'b0;
    repeat (3) @(posedge pclk);
    apb(STAT_OFS, 1'b0, 32'h1 << STAT_ST_POS, SM, 1'b0);
    en_above_thr <= 1'b1;
    repeat (3) @(posedge pclk);
    apb(STAT_OFS, 1'b0, 32'h2 << STAT_ST_POS, SM, 1'b0);
    // reset during the start delay returns outputs and period to reset values
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk("reset outputs", 32'h1, 32'({dac_level, sense_offset, ov_trip_sel, pwm_oe,
                                     power_ok_out_oe}));
    apb(CTRL_OFS, 1'b0, 32'(CTRL_PERIOD_RST), 32'h3ff, 1'b0);
    repeat (12) @(posedge pclk);
    apb(STAT_OFS, 1'b0, 32'h2 << STAT_ST_POS, SM, 1'b0);
    repeat (4) @(posedge pclk);
    finish_test();
  end
endmodule
